// ===== verilog/pd_tx_token_framer.sv
// transmit token framer with fifo port register and receive queue
`timescale 1ns/1ps
module pd_tx_token_framer
  import pd_tx_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  pd_port_if.device_end   port,
  input  wire logic       tx_start,
  input  wire logic       cc_activity,
  output logic [4:0]      sym,
  output logic            sym_valid,
  input  wire logic       sym_ready,
  output logic            drv_en,
  output logic            collision,
  output logic            tx_full,
  output logic            tx_empty,
  output logic            alert,
  input  wire logic [7:0] rx_byte,
  input  wire logic       rx_push,
  output logic            rx_full,
  output logic            rx_empty
);

  typedef enum logic [2:0] {IDLE, FETCH, KSYM, SEND, DATA} state_type;

  // --------------------------------------------------------------------
  // port decode
  // --------------------------------------------------------------------
  wire port_hit = port.addr == FIFO_TOKEN_PORT;
  wire wr_hit   = port.wr && port_hit;
  wire rd_hit   = port.rd && port_hit;
  wire transmitter_on_command_wr  = wr_hit && is_transmitter_on_command(port.wdata);
  wire tx_push  = wr_hit && !transmitter_on_command_wr && !tx_full;
  wire rx_pop   = rd_hit && !rx_empty;
  wire go       = transmitter_on_command_wr || tx_start;

  // --------------------------------------------------------------------
  // transmit queue
  // --------------------------------------------------------------------
  logic [7:0]      tx_mem [TX_DEPTH];
  logic [TX_AW-1:0] tx_wp;
  logic [TX_AW-1:0] tx_rp;
  logic [TX_AW:0]   tx_cnt;
  state_type        state;
  logic             flush;

  wire [7:0] head = tx_mem[tx_rp];
  wire tx_pop = (state == FETCH || state == DATA) && !tx_empty
                && !sym_valid;

  assign tx_full  = tx_cnt == TX_AW'(0) + (TX_AW+1)'(TX_DEPTH);
  assign tx_empty = tx_cnt == '0;
  assign alert    = tx_full;

  always_ff @(posedge clk) begin
    if (tx_push) begin
      tx_mem[tx_wp] <= port.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || flush) begin
      tx_wp  <= '0;
      tx_rp  <= '0;
      tx_cnt <= '0;
    end else begin
      if (tx_push) tx_wp <= tx_wp + 1'b1;
      if (tx_pop)  tx_rp <= tx_rp + 1'b1;
      tx_cnt <= tx_cnt + (TX_AW+1)'(tx_push) - (TX_AW+1)'(tx_pop);
    end
  end

  // --------------------------------------------------------------------
  // receive queue, popped by port reads
  // --------------------------------------------------------------------
  logic [7:0]       rx_mem [RX_DEPTH];
  logic [RX_AW-1:0] rx_wp;
  logic [RX_AW-1:0] rx_rp;
  logic [RX_AW:0]   rx_cnt;
  wire rx_in = rx_push && !rx_full;

  assign rx_full  = rx_cnt == (RX_AW+1)'(RX_DEPTH);
  assign rx_empty = rx_cnt == '0;

  always_ff @(posedge clk) begin
    if (rx_in) begin
      rx_mem[rx_wp] <= rx_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rx_wp  <= '0;
      rx_rp  <= '0;
      rx_cnt <= '0;
    end else begin
      if (rx_in)  rx_wp <= rx_wp + 1'b1;
      if (rx_pop) rx_rp <= rx_rp + 1'b1;
      rx_cnt <= rx_cnt + (RX_AW+1)'(rx_in) - (RX_AW+1)'(rx_pop);
    end
  end

  // read data one cycle after the strobe; empty or unmapped reads zero
  always_ff @(posedge clk) begin
    if (!resetn) begin
      port.rdata <= FIFO_TOKEN_PORT_RESET;
    end else if (port.rd) begin
      port.rdata <= rx_pop ? rx_mem[rx_rp] : 8'h00;
    end
  end

  // --------------------------------------------------------------------
  // token decode
  // --------------------------------------------------------------------
  wire       tok_sync = head == SYNC_ONE_TOKEN || head == SYNC_TWO_TOKEN
                        || head == SYNC_THREE_TOKEN;
  wire       tok_k    = tok_sync || head == RESET_ONE_TOKEN
                        || head == RESET_TWO_TOKEN
                        || head == PACKET_END_TOKEN;
  logic [4:0] kcode;

  always_comb begin
    kcode = K_PACKET_END;
    case (head)
      SYNC_ONE_TOKEN:   kcode = K_SYNC_ONE;
      SYNC_TWO_TOKEN:   kcode = K_SYNC_TWO;
      SYNC_THREE_TOKEN: kcode = K_SYNC_THREE;
      RESET_ONE_TOKEN:  kcode = K_RESET_ONE;
      RESET_TWO_TOKEN:  kcode = K_RESET_TWO;
      default:          kcode = K_PACKET_END;
    endcase
  end

  // --------------------------------------------------------------------
  // transmit sequencer
  // --------------------------------------------------------------------
  logic [4:0]  kpend;
  logic [31:0] shift;
  logic [3:0]  left;
  logic [4:0]  bytes_left;
  logic [31:0] crc;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state      <= IDLE;
      sym        <= 5'h00;
      sym_valid  <= 1'b0;
      drv_en     <= 1'b0;
      collision  <= 1'b0;
      flush      <= 1'b0;
      kpend      <= 5'h00;
      shift      <= 32'h0;
      left       <= 4'h0;
      bytes_left <= 5'h00;
      crc        <= CRC_INIT;
    end else begin
      collision <= 1'b0;
      flush     <= 1'b0;
      if (sym_valid && sym_ready) sym_valid <= 1'b0;
      case (state)
        IDLE: begin
          if (go && cc_activity) begin
            collision <= 1'b1;
            flush     <= 1'b1;
          end else if (go) begin
            drv_en <= 1'b1;
            state  <= FETCH;
          end
        end
        FETCH: begin
          if (tx_pop) begin
            if (tok_k) begin
              kpend <= kcode;
              state <= KSYM;
              if (tok_sync) crc <= CRC_INIT;
            end else if (is_packed(head)) begin
              bytes_left <= head[4:0];
              if (head[4:0] != 5'h00) state <= DATA;
            end else if (head == INSERT_CHECKSUM_TOKEN) begin
              shift <= ~crc;
              left  <= CRC_NIBBLES;
              state <= SEND;
            end else if (head == DRIVER_OFF_TOKEN) begin
              drv_en <= 1'b0;
              state  <= IDLE;
            end
          end
        end
        KSYM: begin
          if (!sym_valid) begin
            sym       <= kpend;
            sym_valid <= 1'b1;
            state     <= FETCH;
          end
        end
        DATA: begin
          if (tx_pop) begin
            crc        <= crc_byte(crc, head);
            shift      <= {24'h0, head};
            left       <= 4'h2;
            bytes_left <= bytes_left - 5'h01;
            state      <= SEND;
          end
        end
        SEND: begin
          if (!sym_valid) begin
            sym       <= enc_4b5b(shift[3:0]);
            sym_valid <= 1'b1;
            shift     <= shift >> 4;
            left      <= left - 4'h1;
            if (left == 4'h1) begin
              state <= (bytes_left != 5'h00) ? DATA : FETCH;
            end
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

endmodule // pd_tx_token_framer

// ===== verilog/pd_tx_pkg.sv
// constants, token codes and helpers shared by both ends of the port
package pd_tx_pkg;

  // --------------------------------------------------------------------
  // device port map
  // --------------------------------------------------------------------
  localparam logic [7:0] FIFO_TOKEN_PORT = 8'h43;
  localparam logic [7:0] FIFO_TOKEN_PORT_RESET = 8'h00;

  // --------------------------------------------------------------------
  // transmit tokens
  // --------------------------------------------------------------------
  localparam logic [7:0] TRANSMITTER_ON_COMMAND = 8'ha1;
  localparam logic [7:0] TRANSMITTER_ON_COMMAND_MASK              = 8'he1;
  localparam logic [7:0] SYNC_ONE_TOKEN         = 8'h12;
  localparam logic [7:0] SYNC_TWO_TOKEN         = 8'h13;
  localparam logic [7:0] SYNC_THREE_TOKEN       = 8'h1b;
  localparam logic [7:0] RESET_ONE_TOKEN        = 8'h15;
  localparam logic [7:0] RESET_TWO_TOKEN        = 8'h16;
  localparam logic [7:0] PACKED_DATA_TOKEN      = 8'h80;
  localparam logic [2:0] PACKED_DATA_TAG        = 3'h4;
  localparam logic [7:0] INSERT_CHECKSUM_TOKEN  = 8'hff;
  localparam logic [7:0] PACKET_END_TOKEN       = 8'h14;
  localparam logic [7:0] DRIVER_OFF_TOKEN       = 8'hfe;
  localparam logic [4:0] PACKED_MIN             = 5'h02;
  localparam logic [4:0] PACKED_MAX             = 5'h1e;

  // --------------------------------------------------------------------
  // line k-code symbols
  // --------------------------------------------------------------------
  localparam logic [4:0] K_SYNC_ONE   = 5'h18;
  localparam logic [4:0] K_SYNC_TWO   = 5'h11;
  localparam logic [4:0] K_SYNC_THREE = 5'h06;
  localparam logic [4:0] K_RESET_ONE  = 5'h07;
  localparam logic [4:0] K_RESET_TWO  = 5'h19;
  localparam logic [4:0] K_PACKET_END = 5'h0d;

  // --------------------------------------------------------------------
  // checksum and queue sizes
  // --------------------------------------------------------------------
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [3:0]  CRC_NIBBLES = 4'h8;
  localparam int TX_DEPTH = 64;
  localparam int TX_AW    = 6;
  localparam int RX_DEPTH = 8;
  localparam int RX_AW    = 3;

  // --------------------------------------------------------------------
  // controller register offsets
  // --------------------------------------------------------------------
  localparam logic [3:0] HOST_TX_DATA = 4'h0;
  localparam logic [3:0] HOST_START   = 4'h1;
  localparam logic [3:0] HOST_RX_DATA = 4'h2;
  localparam logic [3:0] HOST_STATUS  = 4'h3;
  localparam int         HOST_ERR_BIT = 7;

  // 4b5b data coding
  function automatic logic [4:0] enc_4b5b(input logic [3:0] n);
    logic [4:0] s;
    s = 5'h00;
    case (n)
      4'h0: s = 5'h1e;
      4'h1: s = 5'h09;
      4'h2: s = 5'h14;
      4'h3: s = 5'h15;
      4'h4: s = 5'h0a;
      4'h5: s = 5'h0b;
      4'h6: s = 5'h0e;
      4'h7: s = 5'h0f;
      4'h8: s = 5'h12;
      4'h9: s = 5'h13;
      4'ha: s = 5'h16;
      4'hb: s = 5'h17;
      4'hc: s = 5'h1a;
      4'hd: s = 5'h1b;
      4'he: s = 5'h1c;
      default: s = 5'h1d;
    endcase
    return s;
  endfunction

  // reflected crc-32, one byte, lsb first
  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0]  d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ d[i]) begin
        r = (r >> 1) ^ CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

  function automatic logic is_transmitter_on_command(input logic [7:0] b);
    return (b & TRANSMITTER_ON_COMMAND_MASK) == TRANSMITTER_ON_COMMAND;
  endfunction

  function automatic logic is_packed(input logic [7:0] b);
    return b[7:5] == PACKED_DATA_TAG;
  endfunction

endpackage

// ===== verilog/pd_port_if.sv
// register port between the controller and the framer
`timescale 1ns/1ps
interface pd_port_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;

  modport device_end (input addr, input wdata, input wr, input rd,
                      output rdata);
  modport host_end   (output addr, output wdata, output wr, output rd,
                      input rdata);
endinterface

// ===== verilog/pd_tx_controller.sv
// controller end: loads tokens, starts sending, reads receive bytes
`timescale 1ns/1ps
module pd_tx_controller
  import pd_tx_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  pd_port_if.host_end     port,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wstrobe,
  input  wire logic       rstrobe,
  output logic [7:0]      rdata
);

  logic [4:0] data_left;
  logic       err;
  logic       rx_sel;
  logic [7:0] own_rdata;

  // --------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------
  wire wr_tx    = wstrobe && addr == HOST_TX_DATA;
  wire wr_start = wstrobe && addr == HOST_START;
  wire wr_stat  = wstrobe && addr == HOST_STATUS;
  wire rd_rx    = rstrobe && addr == HOST_RX_DATA;
  wire in_data  = data_left != 5'h00;
  wire tok_pack = !in_data && is_packed(wdata);
  wire bad_cnt  = tok_pack && (wdata[4:0] < PACKED_MIN
                  || wdata[4:0] > PACKED_MAX);
  wire fwd_tx   = wr_tx && !bad_cnt;
  wire refuse   = wr_tx && bad_cnt;

  // --------------------------------------------------------------------
  // port drive; start always sends the exact command value
  // --------------------------------------------------------------------
  assign port.addr  = FIFO_TOKEN_PORT;
  assign port.wr    = fwd_tx || wr_start;
  assign port.wdata = wr_start ? TRANSMITTER_ON_COMMAND : wdata;
  assign port.rd    = rd_rx;
  assign rdata      = rx_sel ? port.rdata : own_rdata;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      data_left <= 5'h00;
      err       <= 1'b0;
      rx_sel    <= 1'b0;
      own_rdata <= 8'h00;
    end else begin
      rx_sel <= rd_rx;
      if (fwd_tx && in_data) begin
        data_left <= data_left - 5'h01;
      end else if (fwd_tx && tok_pack) begin
        data_left <= wdata[4:0];
      end
      if (refuse) begin
        err <= 1'b1;
      end else if (wr_stat) begin
        err <= 1'b0;
      end
      if (rstrobe && addr == HOST_STATUS) begin
        own_rdata <= {err, 2'h0, data_left};
      end else begin
        own_rdata <= 8'h00;
      end
    end
  end

endmodule // pd_tx_controller

// ===== testbench/pd_tx_token_framer_props.sv
// assertions on the port and line side of the framer
`timescale 1ns/1ps
module pd_tx_token_framer_props
  import pd_tx_pkg::*;
(
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       tx_start,
  input wire logic       cc_activity,
  input wire logic [4:0] sym,
  input wire logic       sym_valid,
  input wire logic       sym_ready,
  input wire logic       drv_en,
  input wire logic       collision,
  input wire logic       tx_full,
  input wire logic       tx_empty,
  input wire logic       alert,
  input wire logic       rx_empty
);
  // ----------------------------------------------------------------
  // decode and sequences
  // ----------------------------------------------------------------
  wire logic wr_port = wr && addr == FIFO_TOKEN_PORT;
  wire logic transmitter_on_command_w  = (wdata & TRANSMITTER_ON_COMMAND_MASK) == TRANSMITTER_ON_COMMAND;
  wire logic go_req  = tx_start || (wr_port && transmitter_on_command_w);

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence seq_take;
    sym_valid && sym_ready;
  endsequence

  sequence seq_abandon;
    collision && !drv_en ##1 !collision ##[0:1] tx_empty;
  endsequence

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  AST_PORT_PUSH: assert property (
    wr_port && !transmitter_on_command_w && !tx_full && !drv_en |=> !tx_empty)
    else $error("port write not queued");
  AST_READ_EMPTY: assert property (
    rd && rx_empty |=> rdata == 8'h00) else $error("empty read not zero");
  AST_RDATA_HOLD: assert property (
    !rd |=> $stable(rdata)) else $error("read data moved without read");
  AST_TRANSMITTER_ON_COMMAND_NOT_STORED: assert property (
    wr_port && transmitter_on_command_w && tx_empty |=> tx_empty)
    else $error("start byte stored");
  AST_TRANSMITTER_ON_COMMAND_START: assert property (
    go_req && !drv_en && !cc_activity |=> drv_en)
    else $error("start not taken");
  AST_TRANSMITTER_ON_COMMAND_EXACT: assert property (
    wr_port && transmitter_on_command_w |-> wdata == TRANSMITTER_ON_COMMAND)
    else $error("start byte not exact");
  AST_START_CAUSE: assert property (
    $rose(drv_en) |-> $past(go_req)) else $error("driver on unasked");
  AST_COLL_START: assert property (
    go_req && cc_activity && !drv_en |=> seq_abandon)
    else $error("busy line start not abandoned");
  AST_COLLISION: assert property (
    collision |-> $past(go_req) && $past(cc_activity) && !drv_en)
    else $error("collision without busy start");
  AST_SYM_HOLD: assert property (
    sym_valid && !sym_ready |=> sym_valid && $stable(sym))
    else $error("symbol dropped before taken");
  AST_ONE_AT_A_TIME: assert property (
    seq_take |=> !sym_valid) else $error("symbol reloaded too early");
  AST_SYM_DRIVER: assert property (
    sym_valid |-> drv_en) else $error("symbol with driver off");
  AST_ALERT_FULL: assert property (
    alert == tx_full && !(tx_full && tx_empty))
    else $error("queue flags disagree");
endmodule // pd_tx_token_framer_props

// ===== testbench/pd_tx_token_framer_test.sv
// self-checking bench for the framer and its controller
`timescale 1ns/1ps
module pd_tx_token_framer_test
  import pd_tx_pkg::*;
;
  logic        clk = 1'b0, resetn = 1'b0, rd_seen = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00, rx_byte = 8'h00, rdata;
  logic        wstrobe = 0, rstrobe = 0, tx_start = 0, cc_activity = 0;
  logic        sym_ready = 0, rx_push = 0;
  logic [4:0]  sym;
  logic        sym_valid, drv_en, collision, tx_full, tx_empty, alert;
  logic        rx_full, rx_empty;
  logic [31:0] seed = 32'hcc0e, rdy_seed = 32'hcc0e, crc;
  logic [4:0]  exp_sym[$];
  logic [7:0]  exp_rd[$];
  int          fails = 0, total_checks = 0, coll_cnt = 0;
  localparam logic [4:0] ENC [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a,
    5'h0b, 5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b,
    5'h1c, 5'h1d};
  localparam logic [7:0] KTOK [5] = '{SYNC_ONE_TOKEN, SYNC_TWO_TOKEN,
    SYNC_THREE_TOKEN, RESET_ONE_TOKEN, RESET_TWO_TOKEN};
  localparam logic [4:0] KSYM [5] = '{K_SYNC_ONE, K_SYNC_TWO,
    K_SYNC_THREE, K_RESET_ONE, K_RESET_TWO};
  localparam logic [4:0] BAD [3] = '{5'h00, 5'h01, 5'h1f};

  always #5 clk = ~clk;

  pd_port_if i_pd_port_if ();
  pd_tx_controller i_pd_tx_controller (.clk(clk), .resetn(resetn),
    .port(i_pd_port_if.host_end), .addr(addr), .wdata(wdata),
    .wstrobe(wstrobe), .rstrobe(rstrobe), .rdata(rdata));
  pd_tx_token_framer i_pd_tx_token_framer (.clk(clk), .resetn(resetn),
    .port(i_pd_port_if.device_end), .tx_start(tx_start),
    .cc_activity(cc_activity), .sym(sym), .sym_valid(sym_valid),
    .sym_ready(sym_ready), .drv_en(drv_en), .collision(collision),
    .tx_full(tx_full), .tx_empty(tx_empty), .alert(alert),
    .rx_byte(rx_byte), .rx_push(rx_push), .rx_full(rx_full),
    .rx_empty(rx_empty));
  pd_tx_token_framer_props i_pd_tx_token_framer_props (.clk(clk),
    .resetn(resetn), .addr(i_pd_port_if.addr), .wdata(i_pd_port_if.wdata),
    .wr(i_pd_port_if.wr), .rd(i_pd_port_if.rd),
    .rdata(i_pd_port_if.rdata), .tx_start(tx_start),
    .cc_activity(cc_activity), .sym(sym), .sym_valid(sym_valid),
    .sym_ready(sym_ready), .drv_en(drv_en), .collision(collision),
    .tx_full(tx_full), .tx_empty(tx_empty), .alert(alert),
    .rx_empty(rx_empty));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] crc8(input logic [31:0] c,
                                       input logic [7:0]  d);
    for (int i = 0; i < 8; i++)
      c = (c[0] ^ d[i]) ? (c >> 1) ^ CRC_POLY : c >> 1;
    return c;
  endfunction

  task automatic cmp_val(input string n, input logic [7:0] e,
                         input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmp_flag(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic sw_wr(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wstrobe <= 1'b1;
    rstrobe <= 1'b0;
    @(posedge clk);
  endtask

  task automatic sw_rd(input logic [3:0] a, input logic [7:0] e);
    addr <= a;
    rstrobe <= 1'b1;
    wstrobe <= 1'b0;
    exp_rd.push_back(e);
    @(posedge clk);
  endtask

  task automatic sw_idle();
    wstrobe <= 1'b0;
    rstrobe <= 1'b0;
    tx_start <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic wait_off();
    for (int i = 0; i < 3000; i++) begin
      if (drv_en === 1'b0 && exp_sym.size() == 0) break;
      @(posedge clk);
      #1;
    end
    cmp_flag("driver off", 1'b0, drv_en);
    cmp_flag("tx empty", 1'b1, tx_empty);
  endtask

  // whole packet: k tokens, packed bytes, checksum, end, driver off
  task automatic frame(input int n, input logic pin);
    logic [7:0] b;
    crc = CRC_INIT;
    for (int i = 0; i < 5; i++) begin
      sw_wr(HOST_TX_DATA, KTOK[i]);
      exp_sym.push_back(KSYM[i]);
    end
    sw_wr(HOST_TX_DATA, {PACKED_DATA_TAG, 5'(n)});
    for (int i = 0; i < n; i++) begin
      seed = nxt(seed);
      b = seed[7:0];
      // a data byte shaped like the start command would start, not queue
      if ((b & TRANSMITTER_ON_COMMAND_MASK) == TRANSMITTER_ON_COMMAND)
        b[0] = 1'b0;
      sw_wr(HOST_TX_DATA, b);
      crc = crc8(crc, b);
      exp_sym.push_back(ENC[b[3:0]]);
      exp_sym.push_back(ENC[b[7:4]]);
    end
    sw_wr(HOST_TX_DATA, INSERT_CHECKSUM_TOKEN);
    for (int i = 0; i < 8; i++)
      exp_sym.push_back(ENC[~crc[4*i +: 4]]);
    sw_wr(HOST_TX_DATA, PACKET_END_TOKEN);
    exp_sym.push_back(K_PACKET_END);
    sw_wr(HOST_TX_DATA, DRIVER_OFF_TOKEN);
    if (pin) begin
      wstrobe <= 1'b0;
      tx_start <= 1'b1;
      @(posedge clk);
    end else begin
      sw_wr(HOST_TX_DATA, TRANSMITTER_ON_COMMAND);
    end
    sw_idle();
    wait_off();
  endtask

  task automatic stop_test();
    cmp_flag("symbols sent", 1'b1, exp_sym.size() == 0);
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // monitor and watchdog
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    rdy_seed <= nxt(rdy_seed);
    sym_ready <= rdy_seed[0] | rdy_seed[2];
    if (collision === 1'b1)
      coll_cnt++;
    if (rd_seen)
      cmp_val("read data", exp_rd.pop_front(), rdata);
    rd_seen <= rstrobe;
    if (sym_valid === 1'b1 && sym_ready === 1'b1)
      cmp_val("symbol", exp_sym.size() ? exp_sym.pop_front() : 'x, sym);
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] rx_vals [8];
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    sw_rd(HOST_STATUS, 8'h00);
    sw_rd(HOST_RX_DATA, 8'h00);
    sw_rd(4'h9, 8'h00);
    sw_idle();
    cmp_flag("tx empty", 1'b1, tx_empty);
    cmp_flag("tx full", 1'b0, tx_full);
    cmp_flag("rx empty", 1'b1, rx_empty);
    $display("test reset done");
    foreach (BAD[i]) begin
      sw_wr(HOST_TX_DATA, {PACKED_DATA_TAG, BAD[i]});
      sw_rd(HOST_STATUS, 8'h80);
      sw_wr(HOST_STATUS, 8'h00);
      sw_rd(HOST_STATUS, 8'h00);
    end
    sw_idle();
    cmp_flag("tx empty", 1'b1, tx_empty);
    $display("test count refusal done");
    frame(2, 1'b0);
    $display("test short frame done");
    frame(30, 1'b1);
    $display("test long frame done");
    sw_wr(HOST_TX_DATA, SYNC_ONE_TOKEN);
    wstrobe <= 1'b0;
    cc_activity <= 1'b1;
    tx_start <= 1'b1;
    @(posedge clk);
    sw_idle();
    repeat (3) @(posedge clk);
    cmp_flag("abandon empty", 1'b1, tx_empty);
    sw_wr(HOST_TX_DATA, TRANSMITTER_ON_COMMAND);
    sw_idle();
    repeat (3) @(posedge clk);
    #1;
    cc_activity <= 1'b0;
    cmp_flag("abandon driver", 1'b0, drv_en);
    cmp_flag("start not stored", 1'b1, tx_empty);
    cmp_flag("two collisions", 1'b1, coll_cnt == 2);
    $display("test collision done");
    for (int i = 0; i < 9; i++) begin
      seed = nxt(seed);
      if (i < 8)
        rx_vals[i] = seed[7:0];
      rx_byte <= seed[7:0];
      rx_push <= 1'b1;
      @(posedge clk);
    end
    rx_push <= 1'b0;
    cmp_flag("rx full", 1'b1, rx_full);
    for (int i = 0; i < 8; i++)
      sw_rd(HOST_RX_DATA, rx_vals[i]);
    sw_rd(HOST_RX_DATA, 8'h00);
    sw_idle();
    cmp_flag("rx empty", 1'b1, rx_empty);
    $display("test receive queue done");
    for (int i = 0; i < TX_DEPTH + 1; i++)
      sw_wr(HOST_TX_DATA, 8'h00);
    sw_idle();
    cmp_flag("tx full", 1'b1, tx_full);
    cmp_flag("alert", 1'b1, alert);
    sw_wr(HOST_START, 8'h5a);
    sw_idle();
    for (int i = 0; i < 500 && tx_empty !== 1'b1; i++)
      @(posedge clk);
    #1;
    sw_wr(HOST_TX_DATA, DRIVER_OFF_TOKEN);
    sw_idle();
    wait_off();
    $display("test full queue done");
    stop_test();
  end
endmodule // pd_tx_token_framer_test
